/* include/obh_pkg.sv */
// shared types and constants for the on-chip debug halt logic
package obh_pkg;

  localparam int PC_W          = 16;
  localparam int NUM_CMP       = 4;
  localparam int INSN_W        = 16;
  localparam logic [15:0] HALT_OPCODE = 16'hA5C3; // arbitrary encoding of the halt opcode
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic        CMP_EN_RESET = 1'b0;

  typedef enum logic [1:0] {
    OBH_CMD_NONE,
    OBH_CMD_SET_CMP,
    OBH_CMD_START,
    OBH_CMD_HALT
  } obh_cmd_t;

  // probe command bundle
  typedef struct packed {
    logic              valid;
    obh_cmd_t          cmd;
    logic [1:0]        idx;
    logic              en;
    logic [PC_W-1:0]   addr;
  } obh_probe_cmd_t;

  // core fetch report
  typedef struct packed {
    logic              valid;
    logic [PC_W-1:0]   pc;
    logic [INSN_W-1:0] insn;
  } obh_fetch_t;

  typedef enum logic [1:0] {
    OBH_CAUSE_NONE,
    OBH_CAUSE_HW,
    OBH_CAUSE_SW,
    OBH_CAUSE_PROBE
  } obh_cause_t;

endpackage

/* core/obh_cmp_bank.sv */
// bank of program counter comparators
`timescale 1ns/1ps
`default_nettype none
module obh_cmp_bank #(
  parameter int N = obh_pkg::NUM_CMP,
  parameter int W = obh_pkg::PC_W
) (
  input  wire logic         ref_clk, // core clock
  input  wire logic         nrst,    // async reset, active low
  input  wire logic         wr,      // write one comparator
  input  wire logic [1:0]   wr_idx,  // comparator index
  input  wire logic         wr_en,   // enable for that comparator
  input  wire logic [W-1:0] wr_addr, // match address
  input  wire logic [W-1:0] pc,      // pc to compare
  output logic              hit      // any enabled match
);
  logic [W-1:0] addr [N];
  logic [N-1:0] en;
  logic [N-1:0] match;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cmp
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          addr[g] <= obh_pkg::PC_RESET;
          en[g]   <= obh_pkg::CMP_EN_RESET;
        end else if (wr && wr_idx == 2'(g)) begin
          addr[g] <= wr_addr;
          en[g]   <= wr_en;
        end
      end
      assign match[g] = en[g] && (addr[g] == pc);
    end
  endgenerate

  assign hit = |match;
endmodule
`default_nettype wire

/* core/obh_halt_ctrl.sv */
// halt and resume control of the on-chip debug unit
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - In run mode the core executes freely with no action needed from the probe.
// - Stopped mode stalls only instruction execution; peripherals keep running.
// - Any enabled comparator matching the fetch pc enters stopped mode, except on the first fetch after a start command issued in stopped mode.
// - The number of comparators is a parameter of the unit.
// - Fetching the halt opcode stops execution and enters stopped mode.
// - The core stays halted until the probe issues a start command.
// - Halt opcode support is an option that can be left out.
module obh_halt_ctrl #(
  parameter int NUM_CMP  = obh_pkg::NUM_CMP,
  parameter bit SW_BREAK = 1'b1
) (
  input  wire logic                   ref_clk,   // core clock
  input  wire logic                   nrst,      // async reset, active low
  input  wire obh_pkg::obh_probe_cmd_t probe_cmd, // probe command, one-cycle valid
  input  wire obh_pkg::obh_fetch_t    fetch,     // core fetch, valid when issued
  output logic                        core_run,  // core may execute this cycle
  output logic                        halted,    // stopped mode flag for polling
  output obh_pkg::obh_cause_t         cause,     // reason of last halt
  output logic [obh_pkg::PC_W-1:0]    halt_pc    // pc at which the core stopped
);
  typedef enum logic {RUN, STOPPED} obh_state_t;
  obh_state_t state;
  logic hw_hit;
  logic sw_hit;
  logic skip;
  logic break_now;
  logic start_cmd;
  logic halt_cmd;

  // ----------------------------------------------------------------
  // break detection
  // ----------------------------------------------------------------
  obh_cmp_bank #(.N(NUM_CMP), .W(obh_pkg::PC_W)) u_cmp (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .wr      (probe_cmd.valid && probe_cmd.cmd == obh_pkg::OBH_CMD_SET_CMP),
    .wr_idx  (probe_cmd.idx),
    .wr_en   (probe_cmd.en),
    .wr_addr (probe_cmd.addr),
    .pc      (fetch.pc),
    .hit     (hw_hit)
  );

  assign sw_hit    = SW_BREAK && fetch.insn == obh_pkg::HALT_OPCODE;
  assign start_cmd = probe_cmd.valid && probe_cmd.cmd == obh_pkg::OBH_CMD_START;
  assign halt_cmd  = probe_cmd.valid && probe_cmd.cmd == obh_pkg::OBH_CMD_HALT;
  // skip suppresses the comparator on the first fetch after resume
  assign break_now = state == RUN && fetch.valid && ((hw_hit && !skip) || sw_hit);

  // ----------------------------------------------------------------
  // run / stopped state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= RUN;
    end else begin
      unique case (state)
        RUN:     if (break_now || halt_cmd) state <= STOPPED;
        STOPPED: if (start_cmd) state <= RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      skip <= 1'b0;
    end else if (state == STOPPED && start_cmd) begin
      skip <= 1'b1;
    end else if (fetch.valid) begin
      skip <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cause   <= obh_pkg::OBH_CAUSE_NONE;
      halt_pc <= obh_pkg::PC_RESET;
    end else if (break_now) begin
      cause   <= sw_hit ? obh_pkg::OBH_CAUSE_SW : obh_pkg::OBH_CAUSE_HW;
      halt_pc <= fetch.pc;
    end else if (state == RUN && halt_cmd) begin
      cause   <= obh_pkg::OBH_CAUSE_PROBE;
      halt_pc <= fetch.pc;
    end
  end

  // only the core is gated; peripherals see no signal from here
  assign core_run = state == RUN && !break_now;
  assign halted   = state == STOPPED;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    halted && !start_cmd |=> halted) else $error("left stopped mode without start");
  hw_break_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !halted && fetch.valid && hw_hit && !skip |=> halted) else $error("hw match did not halt");
  sw_break_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !halted && fetch.valid && sw_hit |-> !core_run ##1 halted) else $error("halt opcode did not halt");
  resume_skip_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    halted && start_cmd |=> !halted ##0 skip) else $error("resume did not arm skip");
  no_retrig_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(halted) && fetch.valid && !sw_hit && !halt_cmd |=> !halted) else $error("retriggered on resume");
  stop_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    halted |-> !core_run) else $error("core ran while stopped");
  free_run_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !halted && !fetch.valid && !halt_cmd |-> core_run ##1 !halted) else $error("run stalled");
  sw_opt_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !SW_BREAK && !halted && !hw_hit && !halt_cmd |=> !halted) else $error("opcode halted when omitted");

  hw_cov_c: cover property (@(posedge ref_clk) disable iff (!nrst) cause == obh_pkg::OBH_CAUSE_HW && halted);
  sw_cov_c: cover property (@(posedge ref_clk) disable iff (!nrst) cause == obh_pkg::OBH_CAUSE_SW && halted);
  res_cov_c: cover property (@(posedge ref_clk) disable iff (!nrst) halted ##1 !halted ##[1:4] halted);
endmodule
`default_nettype wire

/* verification/obh_probe_model.sv */
// debug probe model that issues commands to the halt unit
`timescale 1ns/1ps
`default_nettype none
module obh_probe_model (
  input  wire logic               ref_clk,  // core clock
  input  wire logic               halted,   // stopped mode flag
  output obh_pkg::obh_probe_cmd_t probe_cmd // command pulse
);
  initial probe_cmd = '0;
  // one-cycle command, then one idle cycle for the answer
  task automatic send(input obh_pkg::obh_cmd_t c, input logic [1:0] i, input logic e, input logic [15:0] a);
    @(posedge ref_clk);
    probe_cmd <= {1'h1, c, i, e, a};
    @(posedge ref_clk);
    probe_cmd <= '0;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* verification/obh_halt_ctrl_tb.sv */
// self-checking bench for the halt unit
`timescale 1ns/1ps
`default_nettype none
module obh_halt_ctrl_tb;
  logic                    ref_clk, nrst, core_run, halted, hq;
  obh_pkg::obh_probe_cmd_t pcmd;
  obh_pkg::obh_fetch_t     fetch;
  obh_pkg::obh_cause_t     cause;
  logic [15:0]             halt_pc, bp;
  logic [18:0]             q[$];
  logic [18:0]             e;
  int                      failures, checks, cyc;
  obh_probe_model probe_u (.ref_clk(ref_clk), .halted(halted), .probe_cmd(pcmd));
  obh_halt_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .probe_cmd(pcmd), .fetch(fetch),
    .core_run(core_run), .halted(halted), .cause(cause), .halt_pc(halt_pc));
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [17:0] g, input logic [17:0] x);
    checks++;
    if (g !== x) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one fetch; a cause other than none notes an expected halt
  task automatic fet(input logic [15:0] p, input logic [15:0] i, input logic r, input obh_pkg::obh_cause_t c);
    if (c != obh_pkg::OBH_CAUSE_NONE) q.push_back({1'h1, c, p});
    @(posedge ref_clk);
    fetch <= {1'h1, p, i};
    #1 cmp(18'(core_run), 18'(r));
    @(posedge ref_clk);
    fetch <= '0;
  endtask
  // watch for halts and compare against the oldest note
  always @(negedge ref_clk) begin
    hq <= halted;
    if (halted === 1'h1 && hq === 1'h0) begin
      e = q.pop_front();
      cmp({cause, e[18] ? halt_pc : e[15:0]}, e[17:0]);
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    nrst = 1'h0;
    fetch = '0;
    hq = 1'h0;
    void'($urandom(94));
    bp = 16'($urandom);
    repeat (3) @(posedge ref_clk);
    nrst <= 1'h1;
    probe_u.send(obh_pkg::OBH_CMD_START, 2'h0, 1'h0, 16'h0);
    probe_u.send(obh_pkg::OBH_CMD_SET_CMP, 2'h1, 1'h1, bp);
    probe_u.send(obh_pkg::OBH_CMD_SET_CMP, 2'h2, 1'h0, bp + 16'h4);
    fet(bp - 16'h2, 16'h0, 1'h1, obh_pkg::OBH_CAUSE_NONE);
    fet(bp + 16'h4, 16'h0, 1'h1, obh_pkg::OBH_CAUSE_NONE);
    fet(bp, 16'h0, 1'h0, obh_pkg::OBH_CAUSE_HW);
    fet(bp + 16'h2, 16'h0, 1'h0, obh_pkg::OBH_CAUSE_NONE);
    probe_u.send(obh_pkg::OBH_CMD_START, 2'h0, 1'h0, 16'h0);
    cmp(18'(halted), 18'h0);
    fet(bp, 16'h0, 1'h1, obh_pkg::OBH_CAUSE_NONE);
    fet(bp, 16'h0, 1'h0, obh_pkg::OBH_CAUSE_HW);
    $display("comparator test done");
    probe_u.send(obh_pkg::OBH_CMD_START, 2'h0, 1'h0, 16'h0);
    fet(bp + 16'h6, obh_pkg::HALT_OPCODE, 1'h0, obh_pkg::OBH_CAUSE_SW);
    probe_u.send(obh_pkg::OBH_CMD_START, 2'h0, 1'h0, 16'h0);
    $display("halt opcode test done");
    q.push_back({1'h0, obh_pkg::OBH_CAUSE_PROBE, 16'h0});
    probe_u.send(obh_pkg::OBH_CMD_HALT, 2'h0, 1'h0, 16'h0);
    probe_u.send(obh_pkg::OBH_CMD_HALT, 2'h0, 1'h0, 16'h0);
    probe_u.send(obh_pkg::OBH_CMD_START, 2'h0, 1'h0, 16'h0);
    fet(bp + 16'h8, 16'h0, 1'h1, obh_pkg::OBH_CAUSE_NONE);
    cmp(18'(q.size()), 18'h0);
    $display("probe command test done");
    complete_run();
  end
endmodule
`default_nettype wire
